// ===== rtl/cos_cfg.svh
// constants for the ceiling overspeed supervisor
`ifndef COS_CFG_SVH
`define COS_CFG_SVH

`define COS_SPD_W 9
`define COS_FI_MARGIN 9'h003
`define COS_SI_MARGIN 9'h005
`define COS_FI_MARGIN_RR 9'h002
`define COS_SI_MARGIN_RR 9'h004
`define COS_SPD_MAX 9'h1ff
`define COS_SPD_ZERO 9'h000

`define COS_ADDR_W 4
`define COS_ADDR_CTRL 4'h0
`define COS_ADDR_STAT 4'h1
`define COS_ADDR_IRQ_STAT 4'h2
`define COS_ADDR_IRQ_MASK 4'h3
`define COS_ADDR_NOMINAL 4'h4
`define COS_ADDR_FIRST 4'h5
`define COS_ADDR_SECOND 4'h6

`define COS_CTRL_RST 4'h7
`define COS_CTRL_ENABLE 0
`define COS_CTRL_SB_CFG 1
`define COS_CTRL_TCO_CFG 2
`define COS_IRQ_W 4
`define COS_IRQ_SB 0
`define COS_IRQ_EB 1
`define COS_IRQ_DROP 2
`define COS_IRQ_REVOKE 3

`endif

// ===== rtl/cos_pkg.sv
// types for the ceiling overspeed supervisor
`default_nettype none
package cos_pkg;

  typedef enum logic [10:0] {
    COS_MODE_SELF_TEST = 11'h001,
    COS_MODE_NO_CAB = 11'h002,
    COS_MODE_CAB_CHOSEN = 11'h004,
    COS_MODE_BYPASS = 11'h008,
    COS_MODE_MAINT = 11'h010,
    COS_MODE_CODED = 11'h020,
    COS_MODE_TRANS_CODED = 11'h040,
    COS_MODE_SPOT = 11'h080,
    COS_MODE_SPOT_CODE = 11'h100,
    COS_MODE_SPOT_DEGR = 11'h200,
    COS_MODE_OTHER = 11'h400
  } cos_mode_t;

  typedef struct packed {
    logic [8:0] mode_spd;
    logic [8:0] max_train;
    logic [8:0] coded;
    logic [8:0] line;
    logic [8:0] signalling;
    logic [8:0] temp_restr;
  } cos_ceil_t;

  typedef struct packed {
    logic service_brake;
    logic traction_cut;
    logic emergency_brake;
  } cos_demand_t;

  typedef struct packed {
    logic [3:0] addr;
    logic read;
    logic write;
    logic [31:0] writedata;
  } cos_bus_req_t;

  typedef enum logic [1:0] {
    COS_BUS_IDLE = 2'b01,
    COS_BUS_ACK = 2'b10
  } cos_bus_st_t;

  typedef struct packed {
    cos_bus_st_t bus_st;
    logic [31:0] rdata;
    logic [2:0] ctrl;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic irq;
    logic [8:0] nominal;
    logic [8:0] first;
    logic [8:0] second;
    logic [8:0] prev_nominal;
    logic [8:0] drop_second;
    logic drop_active;
    logic csm_active;
    logic tsm_applies;
    logic rsm_applies;
    cos_demand_t dem;
  } cos_state_t;

endpackage
`default_nettype wire

// ===== rtl/cos_supervisor.sv
// ceiling overspeed supervisor: thresholds, brake demands, avalon-mm registers
//
// Our own choices: the register offsets and the Avalon-MM register port.
`include "cos_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module cos_supervisor
  import cos_pkg::*;
#(
  parameter int SPD_W = `COS_SPD_W
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire cos_ceil_t CEIL_I,
  input wire cos_mode_t MODE_I,
  input wire logic CREEP_RELEASE_I,
  input wire logic TSR_DECEL_I,
  input wire logic [8:0] TRAIN_SPEED_I,
  input wire logic TRACTION_DEMAND_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output var cos_demand_t DEMAND_O,
  output logic [8:0] PERMITTED_O,
  output logic [8:0] FIRST_O,
  output logic [8:0] SECOND_O,
  output logic CSM_ACTIVE_O,
  output logic TSM_APPLIES_O,
  output logic RSM_APPLIES_O,
  output logic IRQ_O
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (SPD_W != `COS_SPD_W) begin : g_bad_width
    $error("speed width must match the configured speed width");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // saturating add so a ceiling near full scale cannot wrap to a low threshold
  function automatic logic [8:0] sat_add(input logic [8:0] a, input logic [8:0] b);
    logic [9:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s[9]) begin
      sat_add = `COS_SPD_MAX;
    end else begin
      sat_add = s[8:0];
    end
  endfunction

  function automatic logic [8:0] min2(input logic [8:0] a, input logic [8:0] b);
    min2 = (a < b) ? a : b;
  endfunction

  function automatic logic is_coded(input cos_mode_t m);
    is_coded = (m == COS_MODE_CODED) || (m == COS_MODE_TRANS_CODED);
  endfunction

  function automatic logic is_spot(input cos_mode_t m);
    is_spot = (m == COS_MODE_SPOT) || (m == COS_MODE_SPOT_CODE) ||
              (m == COS_MODE_SPOT_DEGR);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cos_state_t st;
  cos_state_t next_st;
  logic [8:0] next_nominal;
  logic [8:0] fi_margin;
  logic [8:0] si_margin;
  logic [8:0] new_first;
  logic [8:0] new_second;
  logic csm_mode;
  logic revoke_ok;
  logic [3:0] events;
  cos_bus_req_t req;

  assign req = '{addr: AVS_ADDRESS_I, read: AVS_READ_I, write: AVS_WRITE_I,
                 writedata: AVS_WRITEDATA_I};

  always_comb begin
    next_st = st;
    events = 4'h0;

    // ----------------------------------------------------------------
    // ceilings and margins
    // ----------------------------------------------------------------
    next_nominal = min2(min2(min2(CEIL_I.mode_spd, CEIL_I.max_train),
                             min2(CEIL_I.coded, CEIL_I.line)),
                        min2(CEIL_I.signalling, CEIL_I.temp_restr));
    if (is_coded(MODE_I) && CREEP_RELEASE_I) begin
      fi_margin = `COS_FI_MARGIN_RR;
      si_margin = `COS_SI_MARGIN_RR;
    end else begin
      fi_margin = `COS_FI_MARGIN;
      si_margin = `COS_SI_MARGIN;
    end
    new_first = sat_add(next_nominal, fi_margin);
    new_second = sat_add(next_nominal, si_margin);

    csm_mode = !(MODE_I inside {COS_MODE_SELF_TEST, COS_MODE_NO_CAB,
                                COS_MODE_CAB_CHOSEN, COS_MODE_BYPASS, COS_MODE_MAINT});
    next_st.csm_active = csm_mode && st.ctrl[`COS_CTRL_ENABLE];
    next_st.tsm_applies = is_spot(MODE_I) ||
                          (TSR_DECEL_I && !csm_mode ? 1'b0 : TSR_DECEL_I &&
                           (MODE_I inside {COS_MODE_CODED, COS_MODE_OTHER}));
    next_st.rsm_applies = is_spot(MODE_I);

    // ----------------------------------------------------------------
    // drop tracking in coded modes
    // ----------------------------------------------------------------
    next_st.prev_nominal = next_nominal;
    if (!is_coded(MODE_I)) begin
      next_st.drop_active = 1'b0;
    end else if (next_nominal < st.prev_nominal &&
                 TRAIN_SPEED_I >= new_second) begin
      next_st.drop_active = 1'b1;
      next_st.drop_second = st.drop_active ? st.drop_second :
                            sat_add(st.prev_nominal, si_margin);
      events[`COS_IRQ_DROP] = 1'b1;
    end else if (st.drop_active && TRAIN_SPEED_I < new_second) begin
      next_st.drop_active = 1'b0;
    end

    next_st.nominal = next_nominal;
    next_st.first = new_first;
    next_st.second = next_st.drop_active ? next_st.drop_second : new_second;

    // ----------------------------------------------------------------
    // brake intervention, compared against the registered thresholds
    // ----------------------------------------------------------------
    revoke_ok = !TRACTION_DEMAND_I;
    if (!st.csm_active) begin
      if (revoke_ok) begin
        next_st.dem = '0;
      end
    end else if (TRAIN_SPEED_I >= st.second) begin
      next_st.dem.emergency_brake = 1'b1;
    end else if (TRAIN_SPEED_I >= st.first) begin
      if (st.ctrl[`COS_CTRL_SB_CFG]) begin
        next_st.dem.service_brake = 1'b1;
      end else begin
        next_st.dem.emergency_brake = 1'b1;
      end
      if (st.ctrl[`COS_CTRL_TCO_CFG]) begin
        next_st.dem.traction_cut = 1'b1;
      end
    end else if (TRAIN_SPEED_I > st.nominal) begin
      next_st.dem = st.dem;
    end else if (revoke_ok) begin
      if (st.dem != '0) begin
        events[`COS_IRQ_REVOKE] = 1'b1;
      end
      next_st.dem = '0;
    end
    if (next_st.dem.service_brake && !st.dem.service_brake) begin
      events[`COS_IRQ_SB] = 1'b1;
    end
    if (next_st.dem.emergency_brake && !st.dem.emergency_brake) begin
      events[`COS_IRQ_EB] = 1'b1;
    end

    // ----------------------------------------------------------------
    // avalon-mm slave: one wait cycle, then answer
    // ----------------------------------------------------------------
    case (st.bus_st)
      COS_BUS_IDLE: begin
        if (req.read || req.write) begin
          next_st.bus_st = COS_BUS_ACK;
          next_st.rdata = 32'h0000_0000;
          if (req.addr == `COS_ADDR_CTRL) begin
            next_st.rdata = {29'h0, st.ctrl};
          end else if (req.addr == `COS_ADDR_STAT) begin
            next_st.rdata = {26'h0, st.tsm_applies, st.rsm_applies, st.drop_active,
                             st.dem.emergency_brake, st.dem.traction_cut,
                             st.dem.service_brake};
          end else if (req.addr == `COS_ADDR_IRQ_STAT) begin
            next_st.rdata = {28'h0, st.irq_stat};
          end else if (req.addr == `COS_ADDR_IRQ_MASK) begin
            next_st.rdata = {28'h0, st.irq_mask};
          end else if (req.addr == `COS_ADDR_NOMINAL) begin
            next_st.rdata = {23'h0, st.nominal};
          end else if (req.addr == `COS_ADDR_FIRST) begin
            next_st.rdata = {23'h0, st.first};
          end else if (req.addr == `COS_ADDR_SECOND) begin
            next_st.rdata = {23'h0, st.second};
          end
        end
      end
      COS_BUS_ACK: begin
        next_st.bus_st = COS_BUS_IDLE;
        if (req.write) begin
          if (req.addr == `COS_ADDR_CTRL) begin
            next_st.ctrl = req.writedata[2:0];
          end else if (req.addr == `COS_ADDR_IRQ_STAT) begin
            next_st.irq_stat = st.irq_stat & ~req.writedata[3:0];
          end else if (req.addr == `COS_ADDR_IRQ_MASK) begin
            next_st.irq_mask = req.writedata[3:0];
          end
        end
      end
      default: begin
        next_st.bus_st = COS_BUS_IDLE;
      end
    endcase

    // set wins over a same-cycle clear
    next_st.irq_stat = next_st.irq_stat | events;
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      st <= '{bus_st: COS_BUS_IDLE, ctrl: 3'(`COS_CTRL_RST), default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign AVS_READDATA_O = st.rdata;
  // only the idle code has its low bit set, so the flop bit is the wait flag
  assign AVS_WAITREQUEST_O = st.bus_st[0];
  assign DEMAND_O = st.dem;
  assign PERMITTED_O = st.nominal;
  assign FIRST_O = st.first;
  assign SECOND_O = st.second;
  assign CSM_ACTIVE_O = st.csm_active;
  assign TSM_APPLIES_O = st.tsm_applies;
  assign RSM_APPLIES_O = st.rsm_applies;
  assign IRQ_O = st.irq;

endmodule

`default_nettype wire

// ===== test/cos_monitor.sv
// assertion checker for the ceiling overspeed supervisor
`timescale 1ns/1ps
`default_nettype none
module cos_monitor
  import cos_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire cos_ceil_t CEIL_I,
  input wire cos_mode_t MODE_I,
  input wire logic CREEP_RELEASE_I,
  input wire logic [8:0] TRAIN_SPEED_I,
  input wire logic TRACTION_DEMAND_I,
  input wire cos_demand_t DEMAND_O,
  input wire logic [8:0] PERMITTED_O,
  input wire logic [8:0] FIRST_O,
  input wire logic [8:0] SECOND_O,
  input wire logic CSM_ACTIVE_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  logic [53:0] cv;
  logic [8:0] nom;
  logic [8:0] spd;
  logic act;
  logic rr;
  assign cv = CEIL_I;
  assign spd = TRAIN_SPEED_I;
  assign act = CSM_ACTIVE_O;
  assign rr = CREEP_RELEASE_I && (MODE_I inside {COS_MODE_CODED, COS_MODE_TRANS_CODED});
  always_comb begin
    nom = cv[8:0];
    for (int i = 1; i < 6; i++) begin
      if (cv[i*9+:9] < nom) begin
        nom = cv[i*9+:9];
      end
    end
  end
  AST_NOMINAL: assert property (act ##1 act |-> PERMITTED_O == $past(nom))
    else $error("permitted speed not lowest ceiling");
  AST_FIRST: assert property (act ##1 act |-> FIRST_O == PERMITTED_O + ($past(rr) ? 9'h002 : 9'h003))
    else $error("first margin wrong");
  // a held drop must let go once speed has stayed under the first speed
  AST_SECOND: assert property ((act && $stable(CEIL_I) && !CREEP_RELEASE_I && spd < FIRST_O)[*3] |-> SECOND_O == PERMITTED_O + 9'h005)
    else $error("second margin wrong");
  AST_EB: assert property (act && spd >= SECOND_O |=> DEMAND_O.emergency_brake)
    else $error("emergency missing");
  AST_SB: assert property (act && spd >= FIRST_O && spd < SECOND_O |=> DEMAND_O != 3'h0)
    else $error("first level demand missing");
  AST_KEEP: assert property (act && spd > PERMITTED_O && spd < FIRST_O |=> DEMAND_O == $past(DEMAND_O))
    else $error("demand changed in warning band");
  AST_REVOKE: assert property (spd <= PERMITTED_O && !TRACTION_DEMAND_I |=> DEMAND_O == 3'h0)
    else $error("demand not revoked");
  AST_TRACTION: assert property (TRACTION_DEMAND_I |=> (DEMAND_O & $past(DEMAND_O)) == $past(DEMAND_O))
    else $error("demand dropped under traction");
  AST_EXCLUDED: assert property ((MODE_I & 11'h01f) != 11'h000 |=> !CSM_ACTIVE_O)
    else $error("monitoring active in excluded mode");
  cover property (DEMAND_O.emergency_brake);
  cover property (DEMAND_O.service_brake && !DEMAND_O.emergency_brake);
  cover property (SECOND_O > PERMITTED_O + 9'h005);
endmodule
bind cos_supervisor cos_monitor u_mon (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .CEIL_I(CEIL_I),
  .MODE_I(MODE_I), .CREEP_RELEASE_I(CREEP_RELEASE_I), .TRAIN_SPEED_I(TRAIN_SPEED_I),
  .TRACTION_DEMAND_I(TRACTION_DEMAND_I), .DEMAND_O(DEMAND_O), .PERMITTED_O(PERMITTED_O),
  .FIRST_O(FIRST_O), .SECOND_O(SECOND_O), .CSM_ACTIVE_O(CSM_ACTIVE_O));
`default_nettype wire

// ===== test/cos_far_side.sv
// train speed source; any demand slows it one step per cycle unless jump_i is set
`timescale 1ns/1ps
`default_nettype none
module cos_far_side
  import cos_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cos_demand_t dem_i,
  input wire logic [8:0] target_i,
  input wire logic jump_i,
  output logic [8:0] speed_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_o <= 9'h000;
    end else if (jump_i) begin
      speed_o <= target_i;
    end else if (dem_i != 3'h0 && speed_o != 9'h000) begin
      speed_o <= speed_o - 9'h001;
    end else if (speed_o != target_i) begin
      speed_o <= (speed_o < target_i) ? speed_o + 9'h001 : speed_o - 9'h001;
    end
  end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the ceiling overspeed supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cos_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  cos_ceil_t ceil;
  cos_mode_t mode;
  cos_demand_t dem;
  logic creep, tsr, trac, jump, rd, wr, wreq, ceiling_monitoring, target_curve_monitoring, release_monitoring, irq;
  logic [8:0] tgt, spd, perm, fst, snd;
  logic [3:0] adr;
  logic [31:0] wd, rdat, q;
  logic [53:0] rv;
  int fail_count = 0;
  int checks_done = 0;
  integer seed = 32'he9ed7dc0;
  always #5 clk = ~clk;
  cos_supervisor u_dut (.CLK_SYS_I(clk), .RST_I(rst), .CEIL_I(ceil), .MODE_I(mode),
    .CREEP_RELEASE_I(creep), .TSR_DECEL_I(tsr), .TRAIN_SPEED_I(spd), .TRACTION_DEMAND_I(trac),
    .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .DEMAND_O(dem), .PERMITTED_O(perm),
    .FIRST_O(fst), .SECOND_O(snd), .CSM_ACTIVE_O(ceiling_monitoring), .TSM_APPLIES_O(target_curve_monitoring),
    .RSM_APPLIES_O(release_monitoring), .IRQ_O(irq));
  cos_far_side u_far (.clk_i(clk), .rst_i(rst), .dem_i(dem), .target_i(tgt), .jump_i(jump),
    .speed_o(spd));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
      fail_count++;
    end
  endtask
  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 50) begin
      $display("ERROR %0t: bus answer timed out", $time);
      fail_count++;
    end
  endtask
  task automatic thr(input logic [8:0] p, input logic [8:0] f, input logic [8:0] s);
    chk(32'(perm), 32'(p));
    chk(32'(fst), 32'(f));
    chk(32'(snd), 32'(s));
  endtask
  task automatic dmd(input logic [8:0] s, input logic t, input logic [2:0] m, input logic [2:0] e);
    tgt <= s;
    trac <= t;
    tick(3);
    chk(32'(dem & m), 32'(e));
  endtask
  function automatic logic [8:0] min6(input cos_ceil_t c);
    logic [53:0] v;
    logic [8:0] m;
    v = c;
    m = v[8:0];
    for (int i = 1; i < 6; i++) begin
      if (v[i*9+:9] < m) begin
        m = v[i*9+:9];
      end
    end
    return m;
  endfunction
  function automatic logic [2:0] flags(input cos_mode_t m, input logic t);
    logic sp;
    sp = m inside {COS_MODE_SPOT, COS_MODE_SPOT_CODE, COS_MODE_SPOT_DEGR};
    return {(m & 11'h01f) == 11'h000, sp || (t && m inside {COS_MODE_CODED, COS_MODE_OTHER}), sp};
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    ceil = '{default: 9'h064};
    mode = COS_MODE_OTHER;
    {creep, tsr, trac, rd, wr} = 5'h00;
    jump = 1'b1;
    tgt = 9'h000;
    adr = 4'h0;
    wd = 32'h0;
    tick(5);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h7);
    bus(1'b0, 4'hf, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 4'h4, 32'h1ff);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h064);
    for (int i = 0; i < 11; i++) begin
      mode <= cos_mode_t'(11'h001 << i);
      tsr <= i[0];
      tick(3);
      chk(32'({ceiling_monitoring, target_curve_monitoring, release_monitoring}), 32'(flags(mode, tsr)));
    end
    mode <= COS_MODE_OTHER;
    tsr <= 1'b0;
    for (int k = 0; k < 30; k++) begin
      for (int j = 0; j < 6; j++) begin
        rv[j*9+:9] = 9'h032 + 9'($unsigned($random(seed)) % 350);
      end
      ceil <= rv;
      tgt <= 9'($unsigned($random(seed)) % 450);
      jump <= 1'($random(seed));
      trac <= 1'($random(seed));
      tick(3);
      thr(min6(ceil), min6(ceil) + 9'h003, min6(ceil) + 9'h005);
    end
    ceil <= '{default: 9'h064};
    jump <= 1'b1;
    creep <= 1'b1;
    for (int i = 5; i < 8; i++) begin
      mode <= cos_mode_t'(11'h001 << i);
      dmd(9'h000, 1'b0, 3'h7, 3'h0);
      thr(9'h064, i < 7 ? 9'h066 : 9'h067, i < 7 ? 9'h068 : 9'h069);
    end
    creep <= 1'b0;
    mode <= COS_MODE_OTHER;
    dmd(9'h067, 1'b0, 3'h7, 3'h6);
    dmd(9'h069, 1'b0, 3'h1, 3'h1);
    dmd(9'h065, 1'b0, 3'h1, 3'h1);
    dmd(9'h064, 1'b1, 3'h1, 3'h1);
    dmd(9'h064, 1'b0, 3'h7, 3'h0);
    bus(1'b0, 4'h2, 32'h0);
    chk(q & 32'hb, 32'hb);
    chk(32'(irq), 32'h0);
    bus(1'b1, 4'h3, 32'h2);
    tick(2);
    chk(32'(irq), 32'h1);
    bus(1'b1, 4'h2, 32'hf);
    tick(2);
    chk(32'(irq), 32'h0);
    bus(1'b1, 4'h0, 32'h5);
    dmd(9'h067, 1'b0, 3'h7, 3'h3);
    dmd(9'h000, 1'b0, 3'h7, 3'h0);
    bus(1'b1, 4'h0, 32'h6);
    dmd(9'h06e, 1'b0, 3'h7, 3'h0);
    bus(1'b1, 4'h0, 32'h7);
    mode <= COS_MODE_CODED;
    for (int c = 0; c < 2; c++) begin
      creep <= c[0];
      ceil <= '{default: 9'h064};
      dmd(9'h068, 1'b0, 3'h7, c ? 3'h1 : 3'h6);
      ceil.coded <= 9'h05a;
      tick(3);
      thr(9'h05a, c ? 9'h05c : 9'h05d, c ? 9'h068 : 9'h069);
      tgt <= c ? 9'h05d : 9'h05e;
      tick(3);
      chk(32'(snd), c ? 32'h05e : 32'h05f);
      dmd(9'h000, 1'b0, 3'h7, 3'h0);
    end
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
